// file: hdl/usb_host_transaction_control.sv
/*
 Two host transaction engines with an APB register slave and one interrupt.
 Each engine emits token, data and handshake packets to a packet layer on the
 same clock and takes back at most one outcome per transaction.
*/
`include "usb_host_xact_params.svh"

module usb_host_transaction_control #(
   parameter int ENGINES = 2,
   parameter int ADDR_W = 18
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Packet layer
   output usb_host_xact_pkg::pkt_req_type pkt_req [ENGINES],
   input wire logic [ENGINES-1:0] pkt_ready,
   input wire logic [ENGINES-1:0] frame_mark,
   input usb_host_xact_pkg::link_res_type link_res [ENGINES],
   // Interrupt
   output logic irq
);
   import usb_host_xact_pkg::*;

   // ------------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------------
   if (ENGINES != 2 || ADDR_W < 18) begin : g_bad_cfg
      $error("usb_host_transaction_control needs two engines and 18 address bits");
   end

   // Byte address of a register index
   function automatic logic [ADDR_W-1:0] baddr(input logic [15:0] idx);
      return ADDR_W'({idx, 2'b00});
   endfunction

   // ------------------------------------------------------------------------
   // Shared state
   // ------------------------------------------------------------------------
   logic [15:0] ctrl_q [ENGINES];
   logic [15:0] tok_q [ENGINES];
   logic [15:0] cnt_q [ENGINES];
   logic [15:0] res_q [ENGINES];
   logic [15:0] stat_q [ENGINES];
   logic done_q [ENGINES];
   logic [ENGINES-1:0] done_vec;
   logic [ENGINES-1:0] irq_stat_q;
   logic [ENGINES-1:0] irq_mask_q;
   logic pready_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic [15:0] rd_data;
   logic rd_hit;
   logic wr_en;

   assign wr_en = psel && penable && pwrite && pready_q;
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   // ------------------------------------------------------------------------
   // Engines
   // ------------------------------------------------------------------------
   for (genvar i = 0; i < ENGINES; i++) begin : g_eng
      localparam logic [15:0] CTRL_IDX = (i == 0) ? `HOST1_CTRL_IDX : `HOST2_CTRL_IDX;
      localparam logic [15:0] TOK_IDX = (i == 0) ? `HOST1_TOK_IDX : `HOST2_TOK_IDX;
      localparam logic [15:0] CNT_IDX = (i == 0) ? `HOST1_CNT_IDX : `HOST2_CNT_IDX;
      eng_state_type state_q;
      pkt_req_type pkt_q;
      logic pre_sent_q;
      logic [15:0] rxlen_q;
      logic rxdata_q;
      logic wr_ctrl;
      logic wr_tok;
      logic wr_cnt;
      logic need_pre;
      logic [3:0] emit_pid;
      logic [15:0] diff;
      logic [15:0] len_in;

      assign wr_ctrl = wr_en && (paddr == baddr(CTRL_IDX));
      assign wr_tok = wr_en && (paddr == baddr(TOK_IDX));
      assign wr_cnt = wr_en && (paddr == baddr(CNT_IDX));
      assign need_pre = ctrl_q[i][`CTRL_PRE_BIT] && !pre_sent_q;
      assign len_in = link_res[i].len;
      assign diff = cnt_q[i] - len_in;
      assign pkt_req[i] = pkt_q;
      assign done_vec[i] = done_q[i];

      // Packet code for the current emitting state
      always_comb begin
         unique case (state_q)
            S_TOKEN: emit_pid = tok_q[i][7:4];
            S_DATA: emit_pid = ctrl_q[i][`CTRL_SEQ_BIT] ? `PID_DATA1 : `PID_DATA0;
            S_HAND: emit_pid = `PID_ACK;
            default: emit_pid = `PID_PRE;
         endcase
      end

      // Control register; go cleared after completion, software write wins
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            ctrl_q[i] <= `CTRL_RST;
         end else if (wr_ctrl) begin
            ctrl_q[i] <= pwdata[15:0] & `CTRL_WMASK;
         end else if (done_q[i]) begin
            ctrl_q[i][`CTRL_ARM_BIT] <= 1'b0;
         end
      end

      // Token, endpoint and expected count
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            tok_q[i] <= `TOK_RST;
            cnt_q[i] <= `CNT_RST;
         end else begin
            if (wr_tok) begin
               tok_q[i] <= {8'h00, pwdata[7:0]};
            end
            if (wr_cnt) begin
               cnt_q[i] <= pwdata[15:0];
            end
         end
      end

      // Transaction sequencer
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            state_q <= S_IDLE;
            pkt_q <= '0;
            pre_sent_q <= 1'b0;
            stat_q[i] <= `STAT_RST;
            res_q[i] <= `RES_RST;
            rxlen_q <= 16'h0000;
            rxdata_q <= 1'b0;
            done_q[i] <= 1'b0;
         end else begin
            done_q[i] <= 1'b0;
            unique case (state_q)
               S_IDLE: begin
                  if (ctrl_q[i][`CTRL_ARM_BIT] && !done_q[i]) begin
                     stat_q[i] <= `STAT_RST;
                     pre_sent_q <= 1'b0;
                     rxdata_q <= 1'b0;
                     state_q <= ctrl_q[i][`CTRL_SYNC_BIT] ? S_FRAME : S_TOKEN;
                  end
               end
               S_FRAME: begin
                  if (frame_mark[i]) begin
                     state_q <= S_TOKEN;
                  end
               end
               S_TOKEN, S_DATA, S_HAND: begin
                  if (!pkt_q.valid) begin
                     pkt_q.valid <= 1'b1;
                     pkt_q.pid <= need_pre ? `PID_PRE : emit_pid;
                     pkt_q.ep <= tok_q[i][3:0];
                  end else if (pkt_ready[i]) begin
                     pkt_q.valid <= 1'b0;
                     if (need_pre) begin
                        pre_sent_q <= 1'b1;
                     end else begin
                        pre_sent_q <= 1'b0;
                        if (state_q == S_TOKEN) begin
                           if (tok_q[i][7:4] == `PID_IN) begin
                              state_q <= S_WAIT;
                           end else if (tok_q[i][7:4] == `PID_OUT || tok_q[i][7:4] == `PID_SETUP) begin
                              state_q <= S_DATA;
                           end else begin
                              stat_q[i][`ST_ACK] <= 1'b1;
                              done_q[i] <= 1'b1;
                              state_q <= S_IDLE;
                           end
                        end else if (state_q == S_DATA && !ctrl_q[i][`CTRL_ISO_BIT]) begin
                           state_q <= S_WAIT;
                        end else begin
                           // Isochronous data or sent ACK ends it successfully
                           stat_q[i][`ST_ACK] <= 1'b1;
                           done_q[i] <= 1'b1;
                           state_q <= S_IDLE;
                        end
                     end
                  end
               end
               S_WAIT: begin
                  if (link_res[i].valid) begin
                     state_q <= S_IDLE;
                     done_q[i] <= 1'b1;
                     if (link_res[i].timeout) begin
                        stat_q[i][`ST_TMO] <= 1'b1;
                     end else if (link_res[i].err) begin
                        stat_q[i][`ST_ERR] <= 1'b1;
                     end else begin
                        unique case (link_res[i].pid)
                           `PID_ACK: stat_q[i][`ST_ACK] <= 1'b1;
                           `PID_NAK: stat_q[i][`ST_NAK] <= 1'b1;
                           `PID_STALL: stat_q[i][`ST_STALL] <= 1'b1;
                           // Either toggle is taken; sequence is not checked
                           `PID_DATA0, `PID_DATA1: begin
                              rxlen_q <= len_in;
                              rxdata_q <= 1'b1;
                              res_q[i] <= (len_in > cnt_q[i]) ? {`OVER_FILL, diff[9:0]} : diff;
                              stat_q[i][`ST_LEN] <= (len_in != cnt_q[i]);
                              stat_q[i][`ST_OVER] <= (len_in > cnt_q[i]);
                              stat_q[i][`ST_UNDER] <= (len_in < cnt_q[i]);
                              if (ctrl_q[i][`CTRL_ISO_BIT]) begin
                                 stat_q[i][`ST_ACK] <= 1'b1;
                              end else begin
                                 done_q[i] <= 1'b0;
                                 state_q <= S_HAND;
                              end
                           end
                           default: stat_q[i][`ST_ERR] <= 1'b1;
                        endcase
                     end
                  end
               end
            endcase
         end
      end

      // ----------------------------------------------------------------------
      // Checks
      // ----------------------------------------------------------------------
      a_arm_clear: assert property (@(posedge pclk) disable iff (!presetn)
         (done_q[i] && !wr_ctrl) |=> !ctrl_q[i][`CTRL_ARM_BIT])
         else $error("go bit not cleared after transaction end");
      a_pre_lead: assert property (@(posedge pclk) disable iff (!presetn)
         (pkt_q.valid && pkt_ready[i] && ctrl_q[i][`CTRL_PRE_BIT] && pkt_q.pid != `PID_PRE) |-> pre_sent_q)
         else $error("low-speed packet sent without preamble");
      a_no_pre: assert property (@(posedge pclk) disable iff (!presetn)
         (pkt_q.valid && !ctrl_q[i][`CTRL_PRE_BIT] && state_q != S_TOKEN) |-> pkt_q.pid != `PID_PRE)
         else $error("preamble sent while lead-in disabled");
      a_data_toggle: assert property (@(posedge pclk) disable iff (!presetn)
         (pkt_q.valid && state_q == S_DATA && pkt_q.pid != `PID_PRE)
         |-> pkt_q.pid == (ctrl_q[i][`CTRL_SEQ_BIT] ? `PID_DATA1 : `PID_DATA0))
         else $error("data packet type does not follow toggle bit");
      a_frame_hold: assert property (@(posedge pclk) disable iff (!presetn)
         (state_q == S_FRAME && !frame_mark[i]) |=> (state_q == S_FRAME && !pkt_q.valid))
         else $error("packet left before frame marker");
      a_over_fill: assert property (@(posedge pclk) disable iff (!presetn)
         (done_q[i] && rxdata_q && stat_q[i][`ST_OVER]) |-> res_q[i][15:10] == `OVER_FILL)
         else $error("overflow result not negative");
      a_under_count: assert property (@(posedge pclk) disable iff (!presetn)
         (done_q[i] && rxdata_q && stat_q[i][`ST_UNDER]) |-> res_q[i] == cnt_q[i] - rxlen_q)
         else $error("underflow result wrong");
      a_size_flag: assert property (@(posedge pclk) disable iff (!presetn)
         (done_q[i] && rxdata_q) |-> stat_q[i][`ST_LEN] == (rxlen_q != cnt_q[i]))
         else $error("size mismatch flag wrong");
      a_iso_ok: assert property (@(posedge pclk) disable iff (!presetn)
         (state_q == S_WAIT && link_res[i].valid && !link_res[i].err && !link_res[i].timeout
          && ctrl_q[i][`CTRL_ISO_BIT] && (link_res[i].pid == `PID_DATA0 || link_res[i].pid == `PID_DATA1))
         |=> stat_q[i][`ST_ACK] && done_q[i])
         else $error("isochronous success not flagged");
      a_token_ep: assert property (@(posedge pclk) disable iff (!presetn)
         pkt_q.valid |-> pkt_q.ep == tok_q[i][3:0])
         else $error("packet endpoint differs from token register");
   end

   // ------------------------------------------------------------------------
   // Interrupt status, mask and line
   // ------------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_q <= '0;
         irq_mask_q <= '0;
         irq <= 1'b0;
      end else begin
         // A completion in the clearing cycle survives the clear
         if (wr_en && paddr == baddr(`IRQ_STAT_IDX)) begin
            irq_stat_q <= (irq_stat_q & ~pwdata[ENGINES-1:0]) | done_vec;
         end else begin
            irq_stat_q <= irq_stat_q | done_vec;
         end
         if (wr_en && paddr == baddr(`IRQ_MASK_IDX)) begin
            irq_mask_q <= pwdata[ENGINES-1:0];
         end
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end

   // ------------------------------------------------------------------------
   // APB read decode
   // ------------------------------------------------------------------------
   always_comb begin
      rd_data = 16'h0000;
      rd_hit = 1'b0;
      for (int e = 0; e < ENGINES; e++) begin
         if (paddr == baddr(e == 0 ? `HOST1_CTRL_IDX : `HOST2_CTRL_IDX)) begin
            rd_data = ctrl_q[e];
            rd_hit = 1'b1;
         end
         if (paddr == baddr(e == 0 ? `HOST1_TOK_IDX : `HOST2_TOK_IDX)) begin
            rd_hit = 1'b1;
         end
         if (paddr == baddr(e == 0 ? `HOST1_CNT_IDX : `HOST2_CNT_IDX)) begin
            rd_data = cnt_q[e];
            rd_hit = 1'b1;
         end
         if (paddr == baddr(e == 0 ? `HOST1_STAT_IDX : `HOST2_STAT_IDX)) begin
            rd_data = stat_q[e];
            rd_hit = 1'b1;
         end
         if (paddr == baddr(e == 0 ? `HOST1_RES_IDX : `HOST2_RES_IDX)) begin
            rd_data = res_q[e];
            rd_hit = 1'b1;
         end
      end
      if (paddr == baddr(`IRQ_STAT_IDX)) begin
         rd_data = {{(16-ENGINES){1'b0}}, irq_stat_q};
         rd_hit = 1'b1;
      end
      if (paddr == baddr(`IRQ_MASK_IDX)) begin
         rd_data = {{(16-ENGINES){1'b0}}, irq_mask_q};
         rd_hit = 1'b1;
      end
   end

   // APB answer registered in setup, ready in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= psel && !penable;
         if (psel && !penable) begin
            prdata_q <= pwrite ? 32'h0000_0000 : {16'h0000, rd_data};
            pslverr_q <= !rd_hit;
         end else begin
            pslverr_q <= 1'b0;
         end
      end
   end

   a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      (|(irq_stat_q & irq_mask_q)) |=> irq)
      else $error("interrupt not raised for unmasked status");

endmodule

// file: hdl/usb_host_xact_params.svh
/*
 Offsets, field positions, token codes and reset values for the two host
 transaction engines. Assumes a 32-bit APB slave that places each 16-bit
 register in one aligned word at byte address four times its index.
*/
`ifndef USB_HOST_XACT_PARAMS_SVH
`define USB_HOST_XACT_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define HOST1_CTRL_IDX 16'hc080
`define HOST1_CNT_IDX 16'hc082
`define HOST1_STAT_IDX 16'hc084
`define HOST1_TOK_IDX 16'hc086
`define HOST1_RES_IDX 16'hc088
`define HOST2_CTRL_IDX 16'hc0a0
`define HOST2_CNT_IDX 16'hc0a2
`define HOST2_STAT_IDX 16'hc0a4
`define HOST2_TOK_IDX 16'hc0a6
`define HOST2_RES_IDX 16'hc0a8
`define IRQ_STAT_IDX 16'hc0f0
`define IRQ_MASK_IDX 16'hc0f2

// ----------------------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------------------
`define CTRL_PRE_BIT 7
`define CTRL_SEQ_BIT 6
`define CTRL_SYNC_BIT 5
`define CTRL_ISO_BIT 4
`define CTRL_ARM_BIT 0
`define CTRL_WMASK 16'h00f1
`define CTRL_RST 16'h0000
`define TOK_RST 16'h0000
`define CNT_RST 16'h0000
`define RES_RST 16'h0000
`define STAT_RST 16'h0000
`define MASK_RST 16'h0000

// ----------------------------------------------------------------------------
// Endpoint status bits
// ----------------------------------------------------------------------------
`define ST_ACK 0
`define ST_ERR 1
`define ST_TMO 2
`define ST_STALL 3
`define ST_NAK 4
`define ST_LEN 5
`define ST_UNDER 6
`define ST_OVER 7

// ----------------------------------------------------------------------------
// Packet identifier codes and overflow fill
// ----------------------------------------------------------------------------
`define PID_SETUP 4'hd
`define PID_IN 4'h9
`define PID_OUT 4'h1
`define PID_SOF 4'h5
`define PID_PRE 4'hc
`define PID_NAK 4'ha
`define PID_STALL 4'he
`define PID_DATA0 4'h3
`define PID_DATA1 4'hb
`define PID_ACK 4'h2
`define OVER_FILL 6'h3f

`endif

// file: hdl/usb_host_xact_pkg.sv
/*
 Types shared by the host transaction engines and their packet layer.
 Assumes the packet layer runs on the same clock as the register side.
*/
package usb_host_xact_pkg;

   // ----------------------------------------------------------------------
   // Carriers and states
   // ----------------------------------------------------------------------
   // Packet handed to the serial interface engine
   typedef struct packed {
      logic valid;
      logic [3:0] pid;
      logic [3:0] ep;
   } pkt_req_type;

   // Outcome reported by the serial interface engine
   typedef struct packed {
      logic valid;
      logic [3:0] pid;
      logic [15:0] len;
      logic err;
      logic timeout;
   } link_res_type;

   typedef enum logic [2:0] {
      S_IDLE,
      S_FRAME,
      S_TOKEN,
      S_DATA,
      S_WAIT,
      S_HAND
   } eng_state_type;

endpackage

// file: test/usb_host_transaction_control_tb.sv
/*
 Self-checking bench: firmware over APB, expected packet queues, checks.
 Assumes the link partner model and the design header and package.
*/
`include "usb_host_xact_params.svh"
module usb_host_transaction_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import usb_host_xact_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [17:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, irq, err;
   logic [1:0] pkt_ready, frame_mark, sync_w, seen;
   logic [3:0] slow = '0;
   pkt_req_type pkt_req [2];
   link_res_type link_res [2];
   link_res_type reply [2] = '{default: '0};
   logic [8:0] q [2][$];
   logic [15:0] res_m [2] = '{16'h0000, 16'h0000};
   logic [3:0] codes [9] = '{`PID_SETUP, `PID_IN, `PID_OUT, `PID_SOF, `PID_PRE, `PID_NAK, `PID_STALL, `PID_DATA0, `PID_DATA1};
   logic [3:0] hsk [3] = '{`PID_ACK, `PID_NAK, `PID_STALL};
   logic [3:0] ins [3] = '{`PID_DATA0, `PID_DATA1, `PID_NAK};
   int num_errors = 0;
   int compares = 0;
   int seed = 56;
   usb_host_transaction_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pkt_req(pkt_req), .pkt_ready(pkt_ready), .frame_mark(frame_mark), .link_res(link_res), .irq(irq));
   usb_link_partner u_partner (.pclk(pclk), .presetn(presetn), .reply(reply), .slow(slow), .pkt_req(pkt_req),
      .pkt_ready(pkt_ready), .frame_mark(frame_mark), .link_res(link_res));
   // Clock
   initial forever #5 pclk = ~pclk;
   // Comparison and verdict
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic summarize;
      $display("Compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // One APB transfer, waits for pready under a bound
   task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do @(posedge pclk); while (pready !== 1'b1 && ++i < 20);
      if (i >= 20) check("pready", 1, 0);
      if (i >= 20) summarize();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [15:0] base(input int e);
      return e ? `HOST2_CTRL_IDX : `HOST1_CTRL_IDX;
   endfunction
   task automatic push(input int e, input logic p, input logic [8:0] v);
      if (p) q[e].push_back({1'b0, `PID_PRE, 4'h0});
      q[e].push_back(v);
   endtask
   // Packet stream against the expected queues
   always @(posedge pclk) begin
      for (int e = 0; e < 2; e++) begin
         if (pkt_req[e].valid === 1'b1 && pkt_ready[e] === 1'b1) begin
            if (q[e].size() == 0) check("packet", 0, 1);
            else if (q[e][0][8]) check("sync", 1, !sync_w[e] || seen[e]);
            if (q[e].size() != 0) check("packet", q[e][0], {q[e][0][8], pkt_req[e].pid, pkt_req[e].ep & {4{q[e][0][8]}}});
            if (q[e].size() != 0) q[e].pop_front();
         end
         if (frame_mark[e] === 1'b1) seen[e] = 1'b1;
      end
   end
   // One transaction from programming to interrupt clear
   task automatic xact(input int e, input logic [3:0] tok, input logic [7:0] ctrl);
      logic [15:0] cnt, len, st;
      logic [3:0] ep, rp;
      logic [1:0] mask, flt;
      logic bad;
      int i;
      cnt = $random(seed) & 16'h0fff;
      len = ($random(seed) & 1) ? cnt : $random(seed) & 16'h0fff;
      ep = $random(seed);
      mask = $random(seed);
      slow <= $random(seed);
      // Error or timeout on the link, only where the engine waits for it
      flt = $random(seed);
      bad = (flt == 2'b01 || flt == 2'b10)
         && (tok == `PID_IN || ((tok == `PID_OUT || tok == `PID_SETUP) && !ctrl[4]));
      st = 16'h0001;
      rp = `PID_ACK;
      push(e, ctrl[7], {1'b1, tok, ep});
      if (tok == `PID_IN) begin
         rp = ctrl[4] ? `PID_DATA0 : ins[{$random(seed)} % 3];
         if (bad) rp = `PID_NAK;
         if (rp != `PID_NAK) st = {len > cnt, len < cnt, len != cnt, 5'h01};
         if (rp != `PID_NAK) res_m[e] = (cnt - len) | (len > cnt ? 16'hfc00 : 16'h0000);
         if (rp != `PID_NAK && !ctrl[4]) push(e, ctrl[7], {1'b0, `PID_ACK, 4'h0});
      end
      else if (tok == `PID_OUT || tok == `PID_SETUP) begin
         rp = ctrl[4] ? `PID_ACK : hsk[{$random(seed)} % 3];
         push(e, ctrl[7], {1'b0, ctrl[6] ? `PID_DATA1 : `PID_DATA0, 4'h0});
      end
      if (rp == `PID_NAK) st = 16'h0010;
      if (rp == `PID_STALL) st = 16'h0008;
      // Link fault outranks any reply code while the engine waits
      if (bad) st = (flt == 2'b01) ? 16'h0002 : 16'h0004;
      reply[e] <= '{valid: 1'b1, pid: rp, len: len, err: flt == 2'b01, timeout: flt == 2'b10};
      sync_w[e] = ctrl[5];
      apb(1, base(e) + 16'h2, cnt); // All set before go
      apb(1, base(e) + 16'h6, {tok, ep});
      apb(1, base(e), ctrl | 8'h01);
      // Frame markers before go must not satisfy the sync check
      seen[e] = 1'b0;
      for (i = 0; i < 40 && (i == 0 || rd[0] !== 1'b0); i++) apb(0, base(e), 0);
      check("control", ctrl, rd);
      if (rd[0] !== 1'b0) summarize();
      apb(0, base(e) + 16'h4, 0);
      check("status", st, rd);
      for (int k = 0; k < 2; k++) apb(0, base(k) + 16'h8, 0);
      check("result", res_m[1], rd);
      apb(0, base(e) + 16'h8, 0);
      check("result", res_m[e], rd);
      check("left", 0, q[e].size());
      apb(1, `IRQ_MASK_IDX, mask);
      apb(0, `IRQ_STAT_IDX, 0);
      check("irq status", 1 << e, rd);
      check("irq", mask[e], irq);
      apb(1, `IRQ_STAT_IDX, 1 << e);
      apb(0, `IRQ_STAT_IDX, 0);
      check("irq", 0, irq);
   endtask
   // Reset, register access, then every token on both engines
   initial begin
      sync_w = '0;
      seen = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      for (int k = 0; k < 2; k++) apb(0, base(k), 0);
      check("control reset", 0, rd);
      apb(0, base(0) + 16'h8, 0);
      check("result reset", 0, rd);
      apb(0, base(0) + 16'h6, 0);
      check("token read", 0, rd);
      apb(1, 16'h0000, 32'h1234);
      check("unmapped", 1, err);
      apb(1, base(0) + 16'h8, 32'hffff);
      apb(0, base(0) + 16'h8, 0);
      check("result write", 0, rd);
      apb(1, base(1), 32'h00f0); // Reserved bits zero
      apb(0, base(1), 0);
      check("reserved", 32'h00f0, rd);
      apb(1, base(1), 0); // Reserved bits zero
      for (int n = 0; n < 27; n++) xact(n % 2, codes[n % 9], $random(seed) & 8'hf0);
      summarize();
   end
   // Watchdog
   initial begin
      #500000;
      num_errors++;
      summarize();
   end
endmodule

// file: test/usb_link_partner.sv
/*
 Far-side packet layer: accepts packets, replies, pulses frame markers.
 Assumes the bench supplies each engine's reply and its ready delay.
*/
`include "usb_host_xact_params.svh"
module usb_link_partner (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bench controls
   input usb_host_xact_pkg::link_res_type reply [2],
   input wire logic [3:0] slow,
   // Packet layer
   input usb_host_xact_pkg::pkt_req_type pkt_req [2],
   output logic [1:0] pkt_ready = '0,
   output logic [1:0] frame_mark = '0,
   output usb_host_xact_pkg::link_res_type link_res [2] = '{default: '0}
);
   timeunit 1ns;
   timeprecision 1ns;
   import usb_host_xact_pkg::*;
   int wt [2] = '{0, 0};
   int rt [2] = '{0, 0};
   int fc = 0;
   // ---------------------------------------------------------------
   // Ready delay, reply timing and free frame marker
   // ---------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pkt_ready <= '0;
         frame_mark <= '0;
         link_res <= '{default: '0};
         fc <= 0;
      end
      else begin
         fc <= (fc == 39) ? 0 : fc + 1;
         frame_mark <= {2{fc == 39}};
         for (int e = 0; e < 2; e++) begin
            pkt_ready[e] <= 1'b0;
            link_res[e] <= '0;
            if (rt[e] != 0) rt[e] <= rt[e] - 1;
            if (rt[e] == 1 && reply[e].valid) link_res[e] <= reply[e]; // Either toggle
            if (pkt_req[e].valid && !pkt_ready[e]) begin
               wt[e] <= (wt[e] >= slow[2*e+:2]) ? 0 : wt[e] + 1;
               if (wt[e] >= slow[2*e+:2]) pkt_ready[e] <= 1'b1;
               if (wt[e] >= slow[2*e+:2] && pkt_req[e].pid inside {`PID_IN, `PID_DATA0, `PID_DATA1}) rt[e] <= 3;
            end
         end
      end
   end
endmodule
